// [rtl/lpsc_params.svh]
`ifndef LPSC_PARAMS_SVH
`define LPSC_PARAMS_SVH
// clock period of the peripheral bus clock
`define LPSC_CLK_NS 4
// register offset and decoded address width
`define LPSC_CTRL_OFS 12'h000
// field positions in the control word
`define LPSC_IO_POR_DIS_BIT 25
`define LPSC_CORE_SVM_DIS_BIT 20
`define LPSC_REG_OFF_BIT 16
`define LPSC_CORE_POR_BLK_BIT 12
`define LPSC_REF_OFF_BIT 11
`define LPSC_QUICK_WK_BIT 10
// value after power-on reset
`define LPSC_CTRL_RST 32'h0001_1800
// exit warm-up times in ns
`define LPSC_RO_WARM_NS 1000
`define LPSC_HFO_WARM_NS 1000
`define LPSC_HFO_FAST_NS 100
`define LPSC_REG_WARM_NS 1200
`define LPSC_REG_FAST_NS 200
// least times, rounded up to whole cycles
`define LPSC_CYC(ns) (((ns) + `LPSC_CLK_NS - 1) / `LPSC_CLK_NS)
`endif

// [rtl/lpsc_pkg.sv]
package lpsc_pkg;
  // deep sleep exit sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RO,
    ST_HFO,
    ST_REG,
    ST_DONE
  } lpsc_state_t;
  // warm-up phases shown to the clock and regulator control
  typedef struct packed {
    logic busy;
    logic ro_warm;
    logic hfo_warm;
    logic reg_warm;
  } lpsc_wake_t;
  // supply and power domain controls
  typedef struct packed {
    logic io_por_mon_en;
    logic core_svm_en;
    logic regulator_on;
    logic bandgap_on;
    logic core_por;
    logic io_dom_rst;
    logic core_dom_rst;
  } lpsc_pwr_t;
endpackage

// [rtl/lpsc_wake_seq.sv]
`timescale 1ns/10ps
`include "lpsc_params.svh"
module lpsc_wake_seq (
  input wire logic clk, // peripheral bus clock
  input wire logic rst_b, // power-on reset, active low
  input wire logic start, // exit request, one cycle
  input wire logic quick, // quick wakeup selected
  output lpsc_pkg::lpsc_wake_t phase, // active warm-up phase
  output logic done // exit finished, one cycle
);
  import lpsc_pkg::*;
  localparam int ro_c = `LPSC_CYC(`LPSC_RO_WARM_NS); // ring oscillator wait
  localparam int hfo_c = `LPSC_CYC(`LPSC_HFO_WARM_NS); // normal oscillator wait
  localparam int hfo_q = `LPSC_CYC(`LPSC_HFO_FAST_NS); // shortened oscillator wait
  localparam int reg_c = `LPSC_CYC(`LPSC_REG_WARM_NS); // normal regulator wait
  localparam int reg_q = `LPSC_CYC(`LPSC_REG_FAST_NS); // shortened regulator wait
  localparam int ro_m1 = ro_c - 1;
  localparam int hfo_m1 = hfo_c - 1;
  localparam int hfq_m1 = hfo_q - 1;
  localparam int reg_m1 = reg_c - 1;
  localparam int rgq_m1 = reg_q - 1;
  lpsc_state_t state_ff, nxt_state; // sequencer state
  logic [11:0] cnt_ff, nxt_cnt; // cycles left in phase
  logic quick_ff, nxt_quick; // quick mode caught at start
  lpsc_wake_t phase_ff, nxt_phase; // registered phase outputs
  logic done_ff, nxt_done; // registered completion
  wire cnt_zero = (cnt_ff == 12'h000); // phase ends
  wire [11:0] hfo_load = quick_ff ? 12'(hfq_m1) : 12'(hfo_m1); // R11
  wire [11:0] reg_load = quick_ff ? 12'(rgq_m1) : 12'(reg_m1); // R11
  // next state and counter loads
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_zero ? cnt_ff : cnt_ff - 12'h001;
    nxt_quick = quick_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_quick = quick;
          if (quick) begin
            // ring oscillator wait skipped
            nxt_state = ST_HFO; // R10
            nxt_cnt = 12'(hfq_m1); // R11
          end else begin
            nxt_state = ST_RO;
            nxt_cnt = 12'(ro_m1);
          end
        end
      end
      ST_RO: begin
        if (cnt_zero) begin
          nxt_state = ST_HFO;
          nxt_cnt = hfo_load;
        end
      end
      ST_HFO: begin
        if (cnt_zero) begin
          nxt_state = ST_REG;
          nxt_cnt = reg_load;
        end
      end
      ST_REG: begin
        if (cnt_zero) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end
  // outputs follow the next state so they come from flops
  assign nxt_phase.busy = (nxt_state != ST_IDLE);
  assign nxt_phase.ro_warm = (nxt_state == ST_RO);
  assign nxt_phase.hfo_warm = (nxt_state == ST_HFO);
  assign nxt_phase.reg_warm = (nxt_state == ST_REG);
  assign nxt_done = (nxt_state == ST_DONE);
  // sequencer registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 12'h000;
      quick_ff <= 1'b0;
      phase_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      quick_ff <= nxt_quick;
      phase_ff <= nxt_phase;
      done_ff <= nxt_done;
    end
  end
  assign phase = phase_ff;
  assign done = done_ff;
  // quick exit never shows the ring oscillator wait
  property p_quick_skip_ro;
    @(posedge clk) disable iff (!rst_b)
    (state_ff == ST_IDLE && start && quick) |=> !phase_ff.ro_warm && phase_ff.hfo_warm;
  endproperty
  a_quick_skip_ro: assert property (p_quick_skip_ro) else $error("ro wait not skipped"); // R10
  // shortened oscillator wait length
  property p_hfo_quick_len;
    @(posedge clk) disable iff (!rst_b)
    ($rose(phase_ff.hfo_warm) && quick_ff) |-> ##hfq_m1 phase_ff.hfo_warm ##1 !phase_ff.hfo_warm;
  endproperty
  a_hfo_quick_len: assert property (p_hfo_quick_len) else $error("quick hfo wait wrong"); // R11
  // shortened regulator wait length
  property p_reg_quick_len;
    @(posedge clk) disable iff (!rst_b)
    ($rose(phase_ff.reg_warm) && quick_ff) |-> ##rgq_m1 phase_ff.reg_warm ##1 done_ff;
  endproperty
  a_reg_quick_len: assert property (p_reg_quick_len) else $error("quick reg wait wrong"); // R11
  // normal ring oscillator wait length
  property p_ro_len;
    @(posedge clk) disable iff (!rst_b)
    $rose(phase_ff.ro_warm) |-> ##ro_m1 phase_ff.ro_warm ##1 phase_ff.hfo_warm;
  endproperty
  a_ro_len: assert property (p_ro_len) else $error("ro wait length wrong"); // R10
endmodule

// [rtl/lpsc_top.sv]
`timescale 1ns/10ps
`include "lpsc_params.svh"
// Summary of operation
// (R1) i/o por monitor on after reset; 1 disables
// (R2) core supply monitor on after reset; 1 disables
// (R3) regulator-off held 1 during supply detection
// (R4) no external supply found: clear regulator-off
// (R5) regulator-off 1 disables regulator, 0 enables
// (R6) blocking bit 1: withhold core por asleep
// (R7) blocking bit 0: core por stays connected
// (R8) reference-off 1: bandgap off while asleep
// (R9) quick wakeup resets off; 1 enables it
// (R10) quick exit skips ring oscillator warm-up
// (R11) quick exit shortens oscillator, regulator warm-up
// (R12) monitored supply low resets its domain
// (R13) reads return all fields, reserved included
module lpsc_top (
  input wire logic clk, // peripheral bus clock
  input wire logic rst_b, // power-on reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic deep_sleep_state, // device in deep sleep
  input wire logic state_a, // device in state_a state
  input wire logic wake_req, // wake event, one cycle
  input wire logic det_done_pin, // core supply detection finished
  input wire logic ext_core_pin, // external core supply seen
  input wire logic io_low_pin, // i/o supply below trigger
  input wire logic core_low_pin, // core supply below trigger
  input wire logic por_pin, // power-on reset event to core
  output lpsc_pkg::lpsc_pwr_t pwr, // supply and domain controls
  output lpsc_pkg::lpsc_wake_t wake_phase, // exit warm-up phase
  output logic wake_done // exit finished, one cycle
);
  import lpsc_pkg::*;
  logic [4:0] pin_raw; // asynchronous pin levels
  logic [4:0] s1_ff, s2_ff, s3_ff; // synchroniser stages
  logic [4:0] pin_ff; // filtered pin levels
  logic [31:0] ctrl_ff, nxt_ctrl; // control register
  logic det_pend_ff; // supply detection still running
  logic [31:0] prdata_ff; // read data
  logic pready_ff; // access phase ready
  logic pslverr_ff; // unmapped access
  lpsc_pwr_t pwr_ff, nxt_pwr; // registered controls
  assign pin_raw = {por_pin, core_low_pin, io_low_pin, ext_core_pin, det_done_pin};
  // three flop synchronisers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_ff <= 5'h00;
      s2_ff <= 5'h00;
      s3_ff <= 5'h00;
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  // a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_filt
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          pin_ff[gi] <= 1'b0;
        end else if (s2_ff[gi] == s3_ff[gi]) begin
          pin_ff[gi] <= s2_ff[gi];
        end
      end
    end
  endgenerate
  wire det_done = pin_ff[0]; // detection finished
  wire ext_core = pin_ff[1]; // external core supply present
  wire io_low = pin_ff[2]; // i/o supply low
  wire core_low = pin_ff[3]; // core supply low
  wire por_evt = pin_ff[4]; // power-on reset request
  // bus decode
  wire setup = psel & ~penable; // apb setup phase
  wire hit = (paddr == `LPSC_CTRL_OFS); // register addressed
  wire wr_en = psel & penable & pready_ff & pwrite & ~pslverr_ff; // write commits
  wire det_fin = det_pend_ff & det_done; // detection completes now
  wire low_power = deep_sleep_state | state_a; // deep sleep or state_a
  // control register next value
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_en) begin
      nxt_ctrl = pwdata; // R1 R2 R9 R13
    end
    if (det_pend_ff) begin
      // hardware owns regulator-off until detection ends
      nxt_ctrl[`LPSC_REG_OFF_BIT] = 1'b1; // R3
    end
    if (det_fin && !ext_core) begin
      // no external supply: internal regulator must run
      nxt_ctrl[`LPSC_REG_OFF_BIT] = 1'b0; // R4
    end
  end
  // control register and detection flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= `LPSC_CTRL_RST;
      det_pend_ff <= 1'b1;
    end else begin
      ctrl_ff <= nxt_ctrl;
      det_pend_ff <= det_pend_ff & ~det_done;
    end
  end
  // apb slave with no wait states
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~hit;
      if (setup) begin
        prdata_ff <= hit ? ctrl_ff : 32'h0000_0000; // R13
      end
    end
  end
  // power controls from the register fields
  assign nxt_pwr.io_por_mon_en = ~ctrl_ff[`LPSC_IO_POR_DIS_BIT]; // R1
  assign nxt_pwr.core_svm_en = ~ctrl_ff[`LPSC_CORE_SVM_DIS_BIT]; // R2
  assign nxt_pwr.regulator_on = ~ctrl_ff[`LPSC_REG_OFF_BIT]; // R5
  assign nxt_pwr.bandgap_on = ~(ctrl_ff[`LPSC_REF_OFF_BIT] & low_power); // R8
  assign nxt_pwr.core_por = por_evt & ~(ctrl_ff[`LPSC_CORE_POR_BLK_BIT] & low_power); // R6 R7
  assign nxt_pwr.io_dom_rst = io_low & ~ctrl_ff[`LPSC_IO_POR_DIS_BIT]; // R12
  assign nxt_pwr.core_dom_rst = core_low & ~ctrl_ff[`LPSC_CORE_SVM_DIS_BIT]; // R12
  // registered power controls
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_ff <= 7'b1101000;
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end
  // deep sleep exit sequencer
  lpsc_wake_seq u_wake (
    .clk(clk),
    .rst_b(rst_b),
    .start(wake_req & deep_sleep_state),
    .quick(ctrl_ff[`LPSC_QUICK_WK_BIT]), // R9
    .phase(wake_phase),
    .done(wake_done)
  );
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pwr = pwr_ff;
  property p_reg_off_held;
    @(posedge clk) disable iff (!rst_b)
    det_pend_ff |-> ctrl_ff[`LPSC_REG_OFF_BIT] && !pwr_ff.regulator_on;
  endproperty
  a_reg_off_held: assert property (p_reg_off_held) else $error("regulator-off dropped early"); // R3
  property p_no_ext_clear;
    @(posedge clk) disable iff (!rst_b)
    (det_fin && !ext_core) |=> !ctrl_ff[`LPSC_REG_OFF_BIT] ##1 pwr_ff.regulator_on;
  endproperty
  a_no_ext_clear: assert property (p_no_ext_clear) else $error("regulator-off not cleared"); // R4
  property p_ext_keep;
    @(posedge clk) disable iff (!rst_b)
    (det_fin && ext_core && !wr_en) |=> ctrl_ff[`LPSC_REG_OFF_BIT];
  endproperty
  a_ext_keep: assert property (p_ext_keep) else $error("regulator-off lost"); // R4
  property p_reg_follow;
    @(posedge clk) disable iff (!rst_b)
    ##1 pwr_ff.regulator_on == !$past(ctrl_ff[`LPSC_REG_OFF_BIT]);
  endproperty
  a_reg_follow: assert property (p_reg_follow) else $error("regulator enable wrong"); // R5
  property p_por_block;
    @(posedge clk) disable iff (!rst_b)
    (ctrl_ff[`LPSC_CORE_POR_BLK_BIT] && low_power) |=> !pwr_ff.core_por;
  endproperty
  a_por_block: assert property (p_por_block) else $error("core por not withheld"); // R6
  property p_por_pass;
    @(posedge clk) disable iff (!rst_b)
    (!ctrl_ff[`LPSC_CORE_POR_BLK_BIT] && por_evt) |=> pwr_ff.core_por;
  endproperty
  a_por_pass: assert property (p_por_pass) else $error("core por not passed"); // R7
  property p_bandgap;
    @(posedge clk) disable iff (!rst_b)
    (ctrl_ff[`LPSC_REF_OFF_BIT] && low_power) |=> !pwr_ff.bandgap_on;
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("bandgap left on"); // R8
  property p_dom_rst;
    @(posedge clk) disable iff (!rst_b)
    (core_low && !ctrl_ff[`LPSC_CORE_SVM_DIS_BIT]) |=> pwr_ff.core_dom_rst;
  endproperty
  a_dom_rst: assert property (p_dom_rst) else $error("core domain not reset"); // R12
  property p_mon_dis;
    @(posedge clk) disable iff (!rst_b)
    (wr_en && pwdata[`LPSC_IO_POR_DIS_BIT]) |=> ##1 !pwr_ff.io_por_mon_en && !pwr_ff.io_dom_rst;
  endproperty
  a_mon_dis: assert property (p_mon_dis) else $error("i/o monitor not disabled"); // R1
  property p_readback;
    @(posedge clk) disable iff (!rst_b)
    (setup && hit) |=> prdata_ff == $past(ctrl_ff) && pready_ff;
  endproperty
  a_readback: assert property (p_readback) else $error("read data wrong"); // R13
  // a committed write lands whole once detection is over
  property p_wr_store;
    @(posedge clk) disable iff (!rst_b)
    (wr_en && !det_pend_ff) |=> ctrl_ff == $past(pwdata);
  endproperty
  a_wr_store: assert property (p_wr_store) else $error("written word not stored"); // R13
  // core monitor disable also withholds its domain reset
  property p_svm_off;
    @(posedge clk) disable iff (!rst_b)
    ctrl_ff[`LPSC_CORE_SVM_DIS_BIT] |=> !pwr_ff.core_svm_en && !pwr_ff.core_dom_rst;
  endproperty
  a_svm_off: assert property (p_svm_off) else $error("core monitor still active"); // R2
  // enabled i/o monitor resets its domain on a low supply
  property p_io_dom_rst;
    @(posedge clk) disable iff (!rst_b)
    (io_low && !ctrl_ff[`LPSC_IO_POR_DIS_BIT]) |=> pwr_ff.io_dom_rst;
  endproperty
  a_io_dom_rst: assert property (p_io_dom_rst) else $error("i/o domain not reset"); // R12
  // bandgap stays up unless asleep with reference-off set
  property p_bandgap_on;
    @(posedge clk) disable iff (!rst_b)
    !(ctrl_ff[`LPSC_REF_OFF_BIT] && low_power) |=> pwr_ff.bandgap_on;
  endproperty
  a_bandgap_on: assert property (p_bandgap_on) else $error("bandgap switched off"); // R8
endmodule

// [tb/lpsc_testbench.sv]
`timescale 1ns/10ps
`include "lpsc_params.svh"
module testbench;
  import lpsc_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr; // clock, reset, apb control
  logic [11:0] paddr; // apb address
  logic [31:0] pwdata, prdata; // apb data
  logic deep_sleep_state, state_a, wake_req, wake_done; // sleep states and wake
  logic det_done_pin, ext_core_pin, io_low_pin, core_low_pin, por_pin; // analog side pins
  lpsc_pwr_t pwr; // supply controls seen at the outputs
  lpsc_wake_t wake_phase; // warm-up phase seen at the outputs
  int n_fail = 0; // mismatch count
  int checks = 0; // comparison count
  // device under test, every input driven by the bench
  lpsc_top uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .deep_sleep_state(deep_sleep_state), .state_a(state_a), .wake_req(wake_req),
    .det_done_pin(det_done_pin), .ext_core_pin(ext_core_pin), .io_low_pin(io_low_pin),
    .core_low_pin(core_low_pin), .por_pin(por_pin), .pwr(pwr), .wake_phase(wake_phase),
    .wake_done(wake_done));
  // free-running bus clock
  initial begin
    clk = 1'b0;
    forever #(`LPSC_CLK_NS / 2.0) clk = ~clk;
  end
  // word comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  // single bit comparison
  task automatic chk_bit(input logic got, input logic exp, input string m);
    chk({31'h0, got}, {31'h0, exp}, m);
  endtask
  // wait a number of rising edges
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer: setup, access, hold until ready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 8);
    if (pready !== 1'b1) begin
      n_fail++;
      $display("ERROR at %0t: no ready from register bus", $time);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // write the control word
  task automatic wr(input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, `LPSC_CTRL_OFS, d, q, e);
  endtask
  // read the control word and compare
  task automatic rd(input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, `LPSC_CTRL_OFS, 32'h0, q, e);
    chk(q, exp, "control read");
  endtask
  // values straight after power-on, detection still pending
  task automatic t_reset();
    rd(`LPSC_CTRL_RST);
    chk_bit(pwr.io_por_mon_en, 1'b1, "io monitor on");
    chk_bit(pwr.core_svm_en, 1'b1, "core monitor on");
    chk_bit(pwr.regulator_on, 1'b0, "regulator off while detecting");
    chk_bit(pwr.bandgap_on, 1'b1, "bandgap on awake");
  endtask
  // detection without external supply, then software control and reserved bits
  task automatic t_detect();
    logic [31:0] q;
    logic e;
    wr(32'h0);
    rd(32'h0001_0000);
    det_done_pin <= 1'b1;
    cyc(12);
    rd(32'h0);
    chk_bit(pwr.regulator_on, 1'b1, "regulator runs");
    wr(32'h0001_0000);
    cyc(2);
    chk_bit(pwr.regulator_on, 1'b0, "regulator disabled by write");
    wr(32'hfdee_e200);
    rd(32'hfdee_e200);
    apb(1'b1, 12'h004, 32'hffff_ffff, q, e);
    chk_bit(e, 1'b1, "unmapped write error");
    apb(1'b0, 12'h004, 32'h0, q, e);
    chk_bit(e, 1'b1, "unmapped read error");
    chk(q, 32'h0, "unmapped read data");
    rd(32'hfdee_e200);
    wr(32'h0);
  endtask
  // supply monitors reset their domain unless disabled
  task automatic t_monitor();
    io_low_pin <= 1'b1;
    core_low_pin <= 1'b1;
    cyc(10);
    chk_bit(pwr.io_dom_rst, 1'b1, "io domain reset");
    chk_bit(pwr.core_dom_rst, 1'b1, "core domain reset");
    wr(32'h0200_0000);
    cyc(2);
    chk_bit(pwr.io_por_mon_en, 1'b0, "io monitor off");
    chk_bit(pwr.io_dom_rst, 1'b0, "io reset withheld");
    chk_bit(pwr.core_dom_rst, 1'b1, "core reset still on");
    wr(32'h0010_0000);
    cyc(2);
    chk_bit(pwr.core_svm_en, 1'b0, "core monitor off");
    chk_bit(pwr.core_dom_rst, 1'b0, "core reset withheld");
    io_low_pin <= 1'b0;
    core_low_pin <= 1'b0;
    wr(32'h0);
    cyc(10);
    chk_bit(pwr.io_dom_rst, 1'b0, "io domain released");
  endtask
  // por gating and bandgap in both low power states
  task automatic t_sleep();
    por_pin <= 1'b1;
    deep_sleep_state <= 1'b1;
    cyc(10);
    chk_bit(pwr.core_por, 1'b1, "por connected, blocking clear");
    chk_bit(pwr.bandgap_on, 1'b1, "bandgap kept on");
    wr(32'h0000_1800);
    cyc(2);
    chk_bit(pwr.core_por, 1'b0, "por blocked in deep sleep");
    chk_bit(pwr.bandgap_on, 1'b0, "bandgap off in deep sleep");
    deep_sleep_state <= 1'b0;
    state_a <= 1'b1;
    cyc(3);
    chk_bit(pwr.core_por, 1'b0, "por blocked in state_a");
    chk_bit(pwr.bandgap_on, 1'b0, "bandgap off in state_a");
    state_a <= 1'b0;
    cyc(3);
    chk_bit(pwr.core_por, 1'b1, "por connected awake");
    chk_bit(pwr.bandgap_on, 1'b1, "bandgap on awake");
    por_pin <= 1'b0;
    wr(32'h0);
  endtask
  // deep sleep exit, counting each warm-up phase
  task automatic t_wake(input logic quick);
    int n, nro, nhfo, nreg;
    n = 0;
    nro = 0;
    nhfo = 0;
    nreg = 0;
    wr(quick ? 32'h0000_0400 : 32'h0);
    wake_req <= 1'b1;
    cyc(1);
    wake_req <= 1'b0;
    cyc(3);
    chk_bit(wake_phase.busy, 1'b0, "wake ignored when awake");
    deep_sleep_state <= 1'b1;
    cyc(1);
    wake_req <= 1'b1;
    cyc(1);
    wake_req <= 1'b0;
    while (wake_done !== 1'b1 && n < 1500) begin
      @(posedge clk);
      n++;
      nro += int'(wake_phase.ro_warm === 1'b1);
      nhfo += int'(wake_phase.hfo_warm === 1'b1);
      nreg += int'(wake_phase.reg_warm === 1'b1);
    end
    chk_bit(wake_done, 1'b1, "exit finished");
    chk(nro, quick ? 0 : `LPSC_CYC(`LPSC_RO_WARM_NS), "ring warm-up");
    chk(nhfo, `LPSC_CYC(quick ? `LPSC_HFO_FAST_NS : `LPSC_HFO_WARM_NS), "hfo warm-up");
    chk(nreg, `LPSC_CYC(quick ? `LPSC_REG_FAST_NS : `LPSC_REG_WARM_NS), "reg warm-up");
    deep_sleep_state <= 1'b0;
    cyc(2);
  endtask
  // second power-on with an external core supply present
  task automatic t_ext();
    rst_b <= 1'b0;
    det_done_pin <= 1'b0;
    ext_core_pin <= 1'b1;
    cyc(12);
    rst_b <= 1'b1;
    cyc(2);
    det_done_pin <= 1'b1;
    cyc(12);
    rd(`LPSC_CTRL_RST);
    chk_bit(pwr.regulator_on, 1'b0, "regulator stays off");
  endtask
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // hang guard, well beyond the expected run
  initial begin
    #(20000 * `LPSC_CLK_NS);
    n_fail++;
    summarize();
  end
  // main sequence
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {deep_sleep_state, state_a, wake_req} = '0;
    {det_done_pin, ext_core_pin, io_low_pin, core_low_pin, por_pin} = '0;
    cyc(12);
    rst_b <= 1'b1;
    t_reset();
    t_detect();
    t_monitor();
    t_sleep();
    t_wake(1'b0);
    t_wake(1'b1);
    t_ext();
    summarize();
  end
endmodule
